// File: pkg/ces_pkg.sv
// constants and types of the can error-status block
package ces_pkg;
    // register addresses (8-bit special function register space)
    localparam logic [15:0] ADDR_TX_ERR_CNT   = 16'hffb5;
    localparam logic [15:0] ADDR_ERR_STATUS   = 16'hffb3;
    localparam logic [15:0] ADDR_RX_ERR_CNT   = 16'hffb6;
    // reset values
    localparam logic [7:0]  RST_ERR_STATUS    = 8'h00;
    localparam logic [7:0]  RST_ERR_CNT       = 8'h00;
    // error status field positions
    localparam int          BIT_BUS_OFF       = 0;
    localparam int          BIT_RX_WARN       = 1;
    localparam int          BIT_TX_WARN       = 2;
    localparam int          BIT_CFG_GRANTED   = 3;
    localparam int          BIT_VALID         = 4;
    localparam int          BIT_WAKE          = 5;
    localparam int          BIT_OVERRUN       = 6;
    // thresholds and counts
    localparam logic [8:0]  BUS_OFF_LIMIT     = 9'h0ff;
    localparam logic [7:0]  WARN_LEVEL        = 8'h60;
    localparam logic [7:0]  IDLE_SEQ_COUNT    = 8'h80;
    localparam logic [3:0]  IDLE_SEQ_BITS     = 4'hb;
    // error counter increments
    localparam logic [3:0]  ERR_INC_TX        = 4'h8;
    localparam logic [3:0]  ERR_INC_RX        = 4'h1;
    localparam logic [3:0]  ERR_INC_RX_DOM    = 4'h8;

    typedef enum logic [2:0] {
        CES_RUN     = 3'b001,
        CES_WAIT    = 3'b010,
        CES_CONFIG  = 3'b100
    } ces_mode_t;
endpackage

// File: rtl/ces_idle_counter.sv
// counter of 128 sequences of 11 recessive bits for bus-off recovery
`timescale 1ns/1ns
module ces_idle_counter
    import ces_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic active,
    input  wire logic bit_tick,
    input  wire logic bus_recessive,
    output logic      done
);
    logic [3:0] bit_q;
    logic [7:0] seq_q;

    always_ff @(posedge clk) begin
        if (rst || !active) begin
            bit_q <= 4'h0;
            seq_q <= 8'h00;
        end else if (bit_tick) begin
            if (!bus_recessive) begin
                bit_q <= 4'h0;
            end else if (bit_q == IDLE_SEQ_BITS - 4'h1) begin
                bit_q <= 4'h0;
                if (seq_q != IDLE_SEQ_COUNT) begin
                    seq_q <= seq_q + 8'h01;
                end
            end else begin
                bit_q <= bit_q + 4'h1;
            end
        end
    end

    assign done = active && (seq_q == IDLE_SEQ_COUNT);
endmodule // ces_idle_counter

// File: rtl/ces_error_status.sv
// error status register and error counters of the can controller
//
// What this block does
// RL1: status reads 00h in reset, 08h after
// RL2: write one clears valid, wake, overrun
// RL3: hardware set wins over cpu clear
// RL4: bus-off set when tx count exceeds 255
// RL5: bus-off cleared by 128x11 recessive or reset
// RL6: interrupt on each bus-off change
// RL7: rx warning at count 96, interrupt on change
// RL8: tx warning at count 96, interrupt on change
// RL9: config grant waits for bus and internal idle
// RL10: config request ignored while bus-off
// RL11: valid set on every error-free frame end
// RL12: config request clears valid and wake
// RL13: wake set on sleep activity or rejection
// RL14: error interrupt held while wake set
// RL15: overrun sets flag and error interrupt
// RL16: clocks at least 16 times bit rate
// RL17: tx overrun keeps transmit request set
// RL18: rx storage overrun raises no receive flags
// RL19: id fetch overrun drops the message
// RL20: tx error counter 8-bit read-only
// RL21: rx error counter 8-bit read-only
// RL22: software uses whole-byte status access only
// RL23: config request does not stop activity
// RL24: protocol reset while bus-off enters config
`timescale 1ns/1ns
module ces_error_status
    import ces_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // cpu byte access
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic [7:0]       rd_data,
    // control register inputs
    input  wire logic        config_request,
    input  wire logic        protocol_machine_reset_bit,
    input  wire logic        sleep_request,
    input  wire logic        sleep_mode,
    // protocol machine events
    input  wire logic        bit_tick,
    input  wire logic        bus_recessive,
    input  wire logic        bus_active,
    input  wire logic        internal_busy,
    input  wire logic        frame_ok,
    input  wire logic        tx_error,
    input  wire logic        tx_success,
    input  wire logic        rx_error,
    input  wire logic        rx_error_dominant,
    input  wire logic        rx_success,
    input  wire logic        rx_active,
    input  wire logic        tx_active,
    // ram access overrun events
    input  wire logic        tx_fetch_overrun,
    input  wire logic        rx_store_overrun,
    input  wire logic        id_fetch_overrun,
    // outputs
    output logic             transmit_request_hold,
    output logic             receive_flags_block,
    output logic             message_drop,
    output logic             protocol_stopped,
    output logic             status_irq,
    output logic             error_irq
);
    logic [8:0] tx_cnt_q;
    logic [7:0] rx_cnt_q;
    logic       bus_off_flag;
    logic       rx_warning_flag;
    logic       tx_warning_flag;
    logic       config_mode_granted;
    logic       valid_q;
    logic       wake_q;
    logic       over_q;
    logic       rx_warn_q;
    logic       tx_warn_q;
    logic       bus_off_q;
    logic       rx_done_q;
    logic       recover_done;
    logic       pm_reset;
    logic       overrun_evt;
    logic       wr_status;
    logic       status_irq_q;
    logic       error_irq_q;
    logic [7:0] status_rd;
    ces_mode_t  mode_q;

    ////////////////////////////////////////////////////////////////////////
    // error counters

    assign pm_reset = protocol_machine_reset_bit && bus_off_q;

    always_ff @(posedge clk) begin
        if (rst || pm_reset || recover_done) begin
            tx_cnt_q <= 9'h000; // RL20
        end else if (!bus_off_q) begin
            if (tx_error) begin
                tx_cnt_q <= tx_cnt_q + {5'h00, ERR_INC_TX}; // RL20
            end else if (tx_success && tx_cnt_q != 9'h000) begin
                tx_cnt_q <= tx_cnt_q - 9'h001; // RL20
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || pm_reset || recover_done) begin
            rx_cnt_q <= RST_ERR_CNT; // RL21
        end else if (rx_error || rx_error_dominant) begin
            if (rx_cnt_q < 8'hf7) begin
                rx_cnt_q <= rx_cnt_q + {4'h0, rx_error_dominant ? ERR_INC_RX_DOM : ERR_INC_RX};
            end
        end else if (rx_success && rx_cnt_q != 8'h00) begin
            rx_cnt_q <= (rx_cnt_q > 8'h7f) ? 8'h77 : rx_cnt_q - 8'h01; // RL21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus-off and warning flags

    ces_idle_counter u_idle (
        .clk           (clk),
        .rst           (rst),
        .active        (bus_off_q),
        .bit_tick      (bit_tick),
        .bus_recessive (bus_recessive),
        .done          (recover_done)
    );

    assign bus_off_flag = tx_cnt_q > BUS_OFF_LIMIT; // RL4

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_off_q <= 1'b0;
        end else if (pm_reset || recover_done) begin
            bus_off_q <= 1'b0; // RL5
        end else if (bus_off_flag) begin
            bus_off_q <= 1'b1; // RL4
        end
    end

    assign rx_warning_flag = rx_cnt_q >= WARN_LEVEL;
    assign tx_warning_flag = tx_cnt_q >= {1'b0, WARN_LEVEL};

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_done_q <= 1'b0;
            rx_warn_q <= 1'b0;
            tx_warn_q <= 1'b0;
        end else begin
            rx_done_q <= rx_success || rx_error || rx_error_dominant
                         || pm_reset || recover_done; // RL7
            if (rx_done_q) begin
                rx_warn_q <= rx_warning_flag; // RL7
            end
            tx_warn_q <= tx_warning_flag; // RL8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration mode grant

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= CES_WAIT;
        end else begin
            case (mode_q)
                CES_RUN: begin
                    if (config_request && !bus_off_q) begin
                        mode_q <= CES_WAIT; // RL23
                    end
                end
                CES_WAIT: begin
                    if (pm_reset) begin
                        mode_q <= CES_CONFIG; // RL24
                    end else if (!config_request) begin
                        mode_q <= CES_RUN;
                    end else if (!bus_off_q && !bus_active && !internal_busy) begin
                        mode_q <= CES_CONFIG; // RL9 RL10
                    end
                end
                CES_CONFIG: begin
                    if (!config_request) begin
                        mode_q <= CES_RUN;
                    end
                end
                default: begin
                    mode_q <= CES_WAIT;
                end
            endcase
            if (pm_reset) begin
                mode_q <= CES_CONFIG; // RL24
            end
        end
    end

    assign config_mode_granted = (mode_q == CES_CONFIG);
    assign protocol_stopped    = config_mode_granted;

    ////////////////////////////////////////////////////////////////////////
    // write-one-to-clear flags

    assign wr_status   = wr_en && (addr == ADDR_ERR_STATUS); // RL22
    assign overrun_evt = tx_fetch_overrun || rx_store_overrun || id_fetch_overrun;

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_q <= 1'b0;
        end else if (frame_ok) begin
            valid_q <= 1'b1; // RL11 RL3
        end else if (config_request || (wr_status && wr_data[BIT_VALID])) begin
            valid_q <= 1'b0; // RL2 RL12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else if ((sleep_mode && bus_active)
                     || (sleep_request && (rx_active || tx_active))) begin
            wake_q <= 1'b1; // RL13 RL3
        end else if (config_request || (wr_status && wr_data[BIT_WAKE])) begin
            wake_q <= 1'b0; // RL2 RL12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            over_q <= 1'b0;
        end else if (overrun_evt) begin
            over_q <= 1'b1; // RL15 RL3
        end else if (wr_status && wr_data[BIT_OVERRUN]) begin
            over_q <= 1'b0; // RL2
        end
    end

    // overrun reactions toward the message handler
    assign transmit_request_hold = tx_fetch_overrun; // RL17
    assign receive_flags_block   = rx_store_overrun; // RL18
    assign message_drop          = id_fetch_overrun; // RL19

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    logic bus_off_d1_q;
    logic rx_warn_d1_q;
    logic tx_warn_d1_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_off_d1_q <= 1'b0;
            rx_warn_d1_q <= 1'b0;
            tx_warn_d1_q <= 1'b0;
            status_irq_q <= 1'b0;
        end else begin
            bus_off_d1_q <= bus_off_q;
            rx_warn_d1_q <= rx_warn_q;
            tx_warn_d1_q <= tx_warn_q;
            status_irq_q <= (bus_off_d1_q != bus_off_q)    // RL6
                         || (rx_warn_d1_q != rx_warn_q)    // RL7
                         || (tx_warn_d1_q != tx_warn_q);   // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            error_irq_q <= 1'b0;
        end else begin
            error_irq_q <= overrun_evt || wake_q; // RL14 RL15
        end
    end

    assign status_irq = status_irq_q;
    assign error_irq  = error_irq_q || wake_q; // RL14

    ////////////////////////////////////////////////////////////////////////
    // register read

    always_comb begin
        status_rd                  = RST_ERR_STATUS;
        status_rd[BIT_BUS_OFF]     = bus_off_q;
        status_rd[BIT_RX_WARN]     = rx_warn_q;
        status_rd[BIT_TX_WARN]     = tx_warn_q;
        status_rd[BIT_CFG_GRANTED] = config_mode_granted; // RL1
        status_rd[BIT_VALID]       = valid_q;
        status_rd[BIT_WAKE]        = wake_q;
        status_rd[BIT_OVERRUN]     = over_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= RST_ERR_STATUS; // RL1
        end else begin
            case (addr)
                ADDR_ERR_STATUS: rd_data <= status_rd;
                ADDR_TX_ERR_CNT: rd_data <= tx_cnt_q[7:0]; // RL20
                ADDR_RX_ERR_CNT: rd_data <= rx_cnt_q;      // RL21
                default:         rd_data <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_status_reset: assert property (@(posedge clk) // RL1
        $fell(rst) |-> (rd_data == 8'h00)) else $error("status not zero in reset");
    chk_w1c_valid: assert property (@(posedge clk) disable iff (rst) // RL2
        wr_status && wr_data[BIT_VALID] && !frame_ok |=> !valid_q)
        else $error("valid not cleared");
    chk_set_wins: assert property (@(posedge clk) disable iff (rst) // RL3
        overrun_evt && wr_status |=> over_q) else $error("clear beat set");
    chk_bus_off_set: assert property (@(posedge clk) disable iff (rst) // RL4
        bus_off_flag && !pm_reset && !recover_done |=> bus_off_q)
        else $error("bus off not set");
    chk_bus_off_irq: assert property (@(posedge clk) disable iff (rst) // RL6
        (bus_off_q != $past(bus_off_q)) |=> status_irq) else $error("no bus off irq");
    chk_cfg_blocked: assert property (@(posedge clk) disable iff (rst) // RL10
        bus_off_q && !pm_reset && !config_mode_granted |=> !config_mode_granted)
        else $error("config granted in bus off");
    chk_pm_reset: assert property (@(posedge clk) disable iff (rst) // RL24
        pm_reset |=> config_mode_granted && !bus_off_q) else $error("reset not config");
    chk_wake_irq: assert property (@(posedge clk) disable iff (rst) // RL14
        wake_q |-> error_irq) else $error("error irq dropped");
endmodule // ces_error_status

// File: test/ces_bus_model.sv
// line-side model: bit timing and bus level of the can wire
`timescale 1ns/1ns
module ces_bus_model #(
    parameter int TICK_DIV = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic idle_bus,
    output logic      bit_tick,
    output logic      bus_recessive,
    output logic      bus_active
);
    int   div_q;
    logic lvl_q;
    ////////////////////////////////////////////////////////////////////////////////
    // bit time of TICK_DIV clocks, 16 clocks per bit by default
    always_ff @(posedge clk) begin
        if (rst || div_q == TICK_DIV - 1) begin
            div_q <= 0;
        end else begin
            div_q <= div_q + 1;
        end
    end
    assign bit_tick = (div_q == TICK_DIV - 1);
    ////////////////////////////////////////////////////////////////////////////////
    // frame traffic flips the line each bit, an idle line is recessive
    always_ff @(posedge clk) begin
        if (rst || idle_bus) begin
            lvl_q <= 1'b1;
        end else if (bit_tick) begin
            lvl_q <= ~lvl_q;
        end
    end
    assign bus_recessive = lvl_q;
    assign bus_active    = !idle_bus;
endmodule // ces_bus_model

// File: test/tb_ces_error_status.sv
// self-checking bench of the can error-status block
`timescale 1ns/1ns
module tb_ces_error_status;
    import ces_pkg::*;
    localparam logic [15:0] ST_A = ADDR_ERR_STATUS;
    localparam logic [15:0] TX_A = ADDR_TX_ERR_CNT;
    localparam logic [15:0] RX_A = ADDR_RX_ERR_CNT;
    logic        clk, rst, wr_en, idle_bus;
    logic [15:0] addr;
    logic [7:0]  wr_data, rd_data, s;
    logic [9:0]  ev;
    logic        config_request, sleep_request, sleep_mode, internal_busy;
    logic        rx_active, tx_active, bit_tick, bus_recessive, bus_active;
    logic        transmit_request_hold, receive_flags_block, message_drop;
    logic        protocol_stopped, status_irq, error_irq;
    wire  [2:0]  ovr = {message_drop, receive_flags_block, transmit_request_hold};
    int          failures, n_compared, sirq, eirq, n, i;
    ////////////////////////////////////////////////////////////////////////////////
    ces_bus_model bus (.clk(clk), .rst(rst), .idle_bus(idle_bus), .bit_tick(bit_tick),
        .bus_recessive(bus_recessive), .bus_active(bus_active));
    ces_error_status dut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_data(rd_data), .config_request(config_request),
        .protocol_machine_reset_bit(ev[9]), .sleep_request(sleep_request),
        .sleep_mode(sleep_mode), .bit_tick(bit_tick), .bus_recessive(bus_recessive),
        .bus_active(bus_active), .internal_busy(internal_busy), .frame_ok(ev[0]),
        .tx_error(ev[1]), .tx_success(ev[2]), .rx_error(ev[3]),
        .rx_error_dominant(ev[4]), .rx_success(ev[5]), .rx_active(rx_active),
        .tx_active(tx_active), .tx_fetch_overrun(ev[6]), .rx_store_overrun(ev[7]),
        .id_fetch_overrun(ev[8]), .transmit_request_hold(transmit_request_hold),
        .receive_flags_block(receive_flags_block), .message_drop(message_drop),
        .protocol_stopped(protocol_stopped), .status_irq(status_irq),
        .error_irq(error_irq));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (status_irq === 1'b1) sirq++;
        if (error_irq === 1'b1) eirq++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        tick;
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        addr = a;
        tick;
        s = rd_data;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        rd(a);
        chk(s, exp);
    endtask
    task automatic pulse(input int b, input int cnt);
        repeat (cnt) begin
            ev[b] = 1'b1;
            tick;
            ev[b] = 1'b0;
            tick;
        end
    endtask
    task automatic wait_st(input int b, input logic v);
        int k;
        k = 0;
        rd(ST_A);
        while (s[b] !== v && k < 30000) begin
            rd(ST_A);
            k++;
        end
        if (k == 30000) begin
            failures++;
            $display("CHECK FAILED t=%0t status bit %0d stuck", $time, b);
            tally_and_finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; addr = ST_A; wr_en = 1'b0; wr_data = 8'h00; ev = '0;
        config_request = 1'b1; sleep_request = 1'b0; sleep_mode = 1'b0;
        internal_busy = 1'b0; rx_active = 1'b0; tx_active = 1'b0; idle_bus = 1'b1;
        failures = 0; n_compared = 0; sirq = 0; eirq = 0;
        repeat (5) @(posedge clk);
        #1;
        chk(rd_data, RST_ERR_STATUS);
        rst = 1'b0;
        tick;
        rdc(ST_A, 8'h08);
        wr(TX_A, 8'h55);
        rdc(TX_A, RST_ERR_CNT);
        wr(RX_A, 8'h55);
        rdc(RX_A, RST_ERR_CNT);
        config_request = 1'b0;
        wait_st(BIT_CFG_GRANTED, 1'b0);
        // valid flag: set, write zero, write one, set against clear
        pulse(0, 1);
        rdc(ST_A, 8'h10);
        wr(ST_A, 8'h00);
        rdc(ST_A, 8'h10);
        wr(ST_A, 8'h10);
        rdc(ST_A, 8'h00);
        addr = ST_A; wr_data = 8'h10; wr_en = 1'b1; ev[0] = 1'b1;
        tick;
        wr_en = 1'b0; ev[0] = 1'b0;
        rdc(ST_A, 8'h10);
        // the three ram overrun situations
        for (i = 0; i < 3; i++) begin
            n = eirq;
            ev[6 + i] = 1'b1;
            #1 chk({7'h0, ovr[i]}, 8'h01);
            tick;
            ev[6 + i] = 1'b0;
            tick;
            tick;
            chk({7'h0, eirq > n}, 8'h01);
            rdc(ST_A, 8'h50);
            wr(ST_A, 8'h40);
        end
        // wake by bus traffic in sleep, then by a refused sleep request
        sleep_mode = 1'b1; idle_bus = 1'b0;
        repeat (3) tick;
        sleep_mode = 1'b0; idle_bus = 1'b1;
        tick;
        rdc(ST_A, 8'h30);
        repeat (4) tick;
        chk({7'h0, error_irq}, 8'h01);
        wr(ST_A, 8'h20);
        tick;
        tick;
        chk({7'h0, error_irq}, 8'h00);
        rx_active = 1'b1; sleep_request = 1'b1;
        tick;
        tick;
        rdc(ST_A, 8'h30);
        sleep_request = 1'b0; rx_active = 1'b0;
        // config request waits for idle and clears valid and wake
        internal_busy = 1'b1; config_request = 1'b1;
        repeat (10) tick;
        rdc(ST_A, 8'h00);
        chk({7'h0, protocol_stopped}, 8'h00);
        internal_busy = 1'b0;
        wait_st(BIT_CFG_GRANTED, 1'b1);
        config_request = 1'b0;
        wait_st(BIT_CFG_GRANTED, 1'b0);
        // receive warning level
        n = sirq;
        pulse(4, 12);
        pulse(3, 1);
        rdc(RX_A, 8'h61);
        pulse(5, 1);
        rdc(RX_A, 8'h60);
        rdc(ST_A, 8'h02);
        chk(8'(sirq - n), 8'h01);
        // transmit warning level and bus-off boundary
        n = sirq;
        pulse(1, 12);
        rdc(TX_A, 8'h60);
        rdc(ST_A, 8'h06);
        chk(8'(sirq - n), 8'h01);
        pulse(1, 19);
        rdc(TX_A, 8'hf8);
        rdc(ST_A, 8'h06);
        n = sirq;
        pulse(1, 1);
        rdc(ST_A, 8'h07);
        tick;
        chk(8'(sirq - n), 8'h01);
        config_request = 1'b1;
        repeat (20) tick;
        rdc(ST_A, 8'h07);
        n = sirq;
        wait_st(BIT_BUS_OFF, 1'b0);
        tick;
        chk({7'h0, sirq > n}, 8'h01);
        wait_st(BIT_CFG_GRANTED, 1'b1);
        config_request = 1'b0;
        wait_st(BIT_CFG_GRANTED, 1'b0);
        // second bus-off left by the protocol machine reset
        pulse(1, 32);
        wait_st(BIT_BUS_OFF, 1'b1);
        config_request = 1'b1;
        pulse(9, 1);
        rd(ST_A);
        chk({7'h0, s[BIT_BUS_OFF]}, 8'h00);
        wait_st(BIT_CFG_GRANTED, 1'b1);
        rdc(ST_A, 8'h08);
        tally_and_finish;
    end
endmodule // tb_ces_error_status
